// file: src/cfm_clock_fail_monitor.sv
`timescale 1ns/1ps

module cfm_clock_fail_monitor
  import cfm_pkg::*;
(
  input  wire logic                     clk_sys,           // System clock, 10 MHz.
  input  wire logic                     reset,             // Synchronous reset, active high.
  input  wire cfm_pkg::cfm_cfg_s        cfg,               // Configuration word fields.
  input  wire logic                     ext_clk,           // External oscillator level.
  input  wire logic                     lf_osc_tick,       // Low-frequency internal oscillator tick.
  input  wire logic                     sleep_exec,        // Sleep instruction executed, pulse.
  input  wire logic                     wake_up,           // Wake-up from sleep, pulse.
  input  wire cfm_pkg::cfm_osc_ctrl_s   ctrl_wdata,        // Control register write data.
  input  wire logic                     ctrl_we,           // Control register write strobe.
  input  wire logic                     flag_wdata,        // Fail flag write data.
  input  wire logic                     flag_we,           // Fail flag write strobe.
  input  wire logic                     osc_fail_int_enable, // Fail interrupt enable.
  output logic                          osc_fail_flag,     // Sticky failure flag.
  output logic                          irq,               // Interrupt request.
  output logic                          use_internal,      // System clock from internal source.
  output logic [3:0]                    internal_freq_sel, // Internal frequency in use.
  output cfm_pkg::cfm_osc_ctrl_s        osc_control_reg,   // Control register readback.
  output cfm_pkg::cfm_osc_status_s      osc_status_reg     // Status readback.
);
  import cfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the external clock level.
  logic ext_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic ext_fall;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_q      <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_q      <= ext_clk;
      ext_sync_q <= ext_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // Only the second stage and later are read, so an unsettled first stage never reaches the logic.
  assign ext_fall = ext_prev_q && !ext_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock divider.
  logic [SAMPLE_CNT_W-1:0] div_q;
  logic                    sample_rise;
  logic                    sample_fall;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_q <= '0;
    end else if (lf_osc_tick) begin
      div_q <= div_q + SAMPLE_CNT_W'(1);
    end
  end

  assign sample_rise = lf_osc_tick && (div_q == SAMPLE_CNT_W'(SAMPLE_DIV - 1));
  assign sample_fall = lf_osc_tick && (div_q == SAMPLE_CNT_W'(SAMPLE_HALF - 1));

  logic fail_pulse;

  cfm_fail_detector u_detector (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .ext_fall    (ext_fall),
    .sample_rise (sample_rise),
    .sample_fall (sample_fall),
    .fail_pulse  (fail_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register and source change detection.
  logic css_change;

  assign css_change = ctrl_we && (ctrl_wdata.clock_source_select != osc_control_reg.clock_source_select);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      osc_control_reg <= '{internal_freq_select: IFS_RESET, clock_source_select: CSS_CONFIG};
    end else if (ctrl_we) begin
      osc_control_reg <= ctrl_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up timer.
  logic                     skip_startup;
  logic                     ext_selected;
  logic [STARTUP_CNT_W-1:0] startup_q;
  logic                     startup_done;

  assign skip_startup = (cfg.osc_mode == CFM_EXTERNAL_CLOCK) || (cfg.osc_mode == CFM_RESISTOR_CAPACITOR);
  assign ext_selected = (osc_control_reg.clock_source_select == CSS_EXT) ||
                        ((osc_control_reg.clock_source_select == CSS_CONFIG) && (cfg.osc_mode != CFM_INTERNAL_ONLY));
  assign startup_done = skip_startup || (startup_q == STARTUP_CNT_W'(STARTUP_EDGES));

  always_ff @(posedge clk_sys) begin
    if (reset || wake_up || css_change) begin
      startup_q <= '0;
    end else if (ext_fall && (startup_q != STARTUP_CNT_W'(STARTUP_EDGES))) begin
      startup_q <= startup_q + STARTUP_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fail-safe condition and clock switching.
  logic monitor_on;
  logic fail_cond_q;
  logic detect;

  assign monitor_on = cfg.fail_monitor_enable_cfg && ext_selected;
  assign detect     = monitor_on && startup_done && fail_pulse;

  // A sleep_exec clear that meets a detection wins: the sticky flag still records it, and a still-dead
  // oscillator sets the condition again at the next sample falling edge, one sample period later.
  always_ff @(posedge clk_sys) begin
    if (reset || sleep_exec || css_change) begin
      fail_cond_q <= 1'b0;
    end else if (detect) begin
      fail_cond_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      use_internal <= 1'b1;
    end else begin
      // With the fail monitor enabled, two-speed start-up keeps the core on the internal clock until the timer ends.
      use_internal <= !ext_selected || fail_cond_q || detect ||
                      (cfg.fail_monitor_enable_cfg && !startup_done);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      internal_freq_sel <= IFS_RESET;
    end else begin
      internal_freq_sel <= osc_control_reg.internal_freq_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flag and interrupt.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      osc_fail_flag <= 1'b0;
    end else if (detect) begin
      osc_fail_flag <= 1'b1;
    end else if (flag_we) begin
      osc_fail_flag <= flag_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= osc_fail_flag && osc_fail_int_enable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      osc_status_reg <= '0;
    end else begin
      osc_status_reg <= '{startup_done: startup_done, running_external: !use_internal,
                          fail_active: fail_cond_q,
                          internal_freq: osc_control_reg.internal_freq_select};
    end
  end
endmodule // cfm_clock_fail_monitor

// file: src/cfm_pkg.sv
package cfm_pkg;

  // Divider from the low-frequency internal oscillator tick to the sample clock.
  localparam int unsigned SAMPLE_DIV       = 64;
  localparam int unsigned SAMPLE_HALF      = SAMPLE_DIV / 2;
  localparam int unsigned SAMPLE_CNT_W     = 6;

  // Start-up timer length, in external clock falling edges.
  localparam int unsigned STARTUP_EDGES    = 1024;
  localparam int unsigned STARTUP_CNT_W    = 11;

  // Clock source select codes.
  localparam logic [1:0]  CSS_CONFIG       = 2'h0;
  localparam logic [1:0]  CSS_EXT          = 2'h1;
  localparam logic [1:0]  CSS_INTERNAL     = 2'h2;

  localparam logic [3:0]  IFS_RESET        = 4'h7;

  // Oscillator modes held in the configuration words: external modes plus internal-only.
  typedef enum logic [2:0] {
    CFM_LOW_POWER_CRYSTAL  = 3'h0,
    CFM_CRYSTAL            = 3'h1,
    CFM_HIGH_SPEED_CRYSTAL = 3'h2,
    CFM_EXTERNAL_CLOCK     = 3'h3,
    CFM_SECONDARY_OSC      = 3'h4,
    CFM_RESISTOR_CAPACITOR = 3'h5,
    CFM_INTERNAL_ONLY      = 3'h6
  } cfm_osc_mode_e;

  // Configuration word fields.
  typedef struct packed {
    logic          fail_monitor_enable_cfg;
    cfm_osc_mode_e osc_mode;
  } cfm_cfg_s;

  // Oscillator control register fields.
  typedef struct packed {
    logic [3:0] internal_freq_select;
    logic [1:0] clock_source_select;
  } cfm_osc_ctrl_s;

  // Oscillator status bits.
  typedef struct packed {
    logic       startup_done;
    logic       running_external;
    logic       fail_active;
    logic [3:0] internal_freq;
  } cfm_osc_status_s;

endpackage

// file: src/cfm_fail_detector.sv
`timescale 1ns/1ps

// Detector latch: set by an external falling edge, cleared by a sample rising edge.
// A failure is reported when the latch is still clear at the end of a sample half-period.
module cfm_fail_detector (
  input  wire logic clk_sys,     // System clock.
  input  wire logic reset,       // Synchronous reset, active high.
  input  wire logic ext_fall,    // External clock falling edge, one cycle.
  input  wire logic sample_rise, // Sample clock rising edge, one cycle.
  input  wire logic sample_fall, // Sample clock falling edge, one cycle.
  output logic      fail_pulse   // Failure seen, one cycle.
);
  logic latch_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch_q <= 1'b0;
    end else if (ext_fall) begin
      latch_q <= 1'b1;
    end else if (sample_rise) begin
      latch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fail_pulse <= 1'b0;
    end else begin
      fail_pulse <= sample_fall && !latch_q && !ext_fall;
    end
  end
endmodule // cfm_fail_detector

// file: dv/cfm_ext_osc_model.sv
`timescale 1ns/1ps

// A failed oscillator freezes at its last level instead of idling.
module cfm_ext_osc_model #(
  parameter int HALF = 2
) (
  input  wire logic clk_sys, // System clock.
  input  wire logic run,     // Oscillator alive.
  output logic      ext_clk  // Oscillator output.
);
  int cnt = 0;
  initial ext_clk = 1'b1;
  always @(posedge clk_sys) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) ext_clk <= ~ext_clk;
    end
  end
endmodule // cfm_ext_osc_model

// file: dv/cfm_clock_fail_monitor_sva.sv
`timescale 1ns/1ps
module cfm_clock_fail_monitor_sva
  import cfm_pkg::*;
(
  input wire logic                     clk_sys,             // Clock.
  input wire logic                     reset,               // Reset.
  input wire cfm_pkg::cfm_cfg_s        cfg,                 // Config.
  input wire logic                     ext_clk,             // Oscillator.
  input wire logic                     lf_osc_tick,         // Tick.
  input wire logic                     sleep_exec,          // Sleep.
  input wire cfm_pkg::cfm_osc_ctrl_s   ctrl_wdata,          // Write data.
  input wire logic                     ctrl_we,             // Write.
  input wire logic                     flag_we,             // Flag write.
  input wire logic                     osc_fail_int_enable, // Irq enable.
  input wire logic                     osc_fail_flag,       // Flag.
  input wire logic                     irq,                 // Irq.
  input wire logic                     use_internal,        // Internal.
  input wire logic [3:0]               internal_freq_sel,   // Frequency.
  input wire cfm_pkg::cfm_osc_ctrl_s   osc_control_reg,     // Control.
  input wire cfm_pkg::cfm_osc_status_s osc_status_reg       // Status.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Low-frequency oscillator ticks since the external clock last fell, saturating.
  logic [5:0] qt_q;
  always_ff @(posedge clk_sys) begin
    if (reset || ($past(ext_clk) && !ext_clk)) qt_q <= 6'h00;
    else if (lf_osc_tick && qt_q != 6'h3F) qt_q <= qt_q + 6'h01;
  end
  property p_irq; ##1 irq == $past(osc_fail_flag && osc_fail_int_enable); endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_en; $rose(osc_fail_flag) |-> cfg.fail_monitor_enable_cfg; endproperty
  a_en: assert property (p_en) else $error("flag while disabled");
  property p_sw; $rose(osc_fail_flag) |-> use_internal ##1 osc_status_reg.fail_active; endproperty
  a_sw: assert property (p_sw) else $error("no switchover");
  property p_stk; osc_fail_flag && !flag_we |=> osc_fail_flag; endproperty
  a_stk: assert property (p_stk) else $error("flag dropped");
  property p_frq; $rose(use_internal) |-> internal_freq_sel == osc_control_reg.internal_freq_select; endproperty
  a_frq: assert property (p_frq) else $error("wrong frequency");
  property p_cs;
    ctrl_we && ctrl_wdata.clock_source_select != osc_control_reg.clock_source_select
      |=> ##1 !osc_status_reg.fail_active;
  endproperty
  a_cs: assert property (p_cs) else $error("select kept failure");
  property p_slp; sleep_exec |-> ##[1:3] !osc_status_reg.fail_active; endproperty
  a_slp: assert property (p_slp) else $error("sleep kept failure");
  property p_qt; $rose(osc_fail_flag) |-> qt_q >= 6'h1F; endproperty
  a_qt: assert property (p_qt) else $error("early failure");
  property p_hld;
    osc_status_reg.fail_active && !$past(ctrl_we) && !$past(sleep_exec) |=> use_internal;
  endproperty
  a_hld: assert property (p_hld) else $error("left internal");
endmodule // cfm_clock_fail_monitor_sva

bind cfm_clock_fail_monitor cfm_clock_fail_monitor_sva u_cfm_clock_fail_monitor_sva (
  .clk_sys, .reset, .cfg, .ext_clk, .lf_osc_tick, .sleep_exec, .ctrl_wdata, .ctrl_we, .flag_we,
  .osc_fail_int_enable, .osc_fail_flag, .irq, .use_internal, .internal_freq_sel, .osc_control_reg,
  .osc_status_reg);

// file: dv/test_clock_fail_monitor.sv
`timescale 1ns/1ps
module test_clock_fail_monitor;
  import cfm_pkg::*;
  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  cfm_cfg_s        cfg = '{1'b1, CFM_EXTERNAL_CLOCK};
  logic            tick = 1'b0, sleep_exec = 1'b0, wake_up = 1'b0, run = 1'b1, ien = 1'b1;
  logic            ctrl_we = 1'b0, flag_we = 1'b0, ext_clk, flag, irq, use_int;
  logic [3:0]      freq;
  cfm_osc_ctrl_s   ctrl_wdata = '0, ctrl_rd;
  cfm_osc_status_s stat;
  int              error_cnt = 0, comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys) tick <= ~tick;
  cfm_ext_osc_model u_cfm_ext_osc_model (.clk_sys(clk_sys), .run(run), .ext_clk(ext_clk));
  cfm_clock_fail_monitor u_cfm_clock_fail_monitor (
    .clk_sys(clk_sys), .reset(reset), .cfg(cfg), .ext_clk(ext_clk), .lf_osc_tick(tick),
    .sleep_exec(sleep_exec), .wake_up(wake_up), .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we),
    .flag_wdata(1'b0), .flag_we(flag_we), .osc_fail_int_enable(ien), .osc_fail_flag(flag), .irq(irq),
    .use_internal(use_int), .internal_freq_sel(freq), .osc_control_reg(ctrl_rd), .osc_status_reg(stat));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr_ctrl(input logic [3:0] f, input logic [1:0] s);
    ctrl_wdata = '{f, s};
    ctrl_we = 1'b1;
    cyc(1);
    ctrl_we = 1'b0;
    cyc(1);
  endtask
  task automatic wait_flag();
    int i;
    for (i = 0; i < 400 && flag !== 1'b1; i++) cyc(1);
    if (flag !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH at %0t: flag never set", $time);
      report_and_stop();
    end
  endtask
  task automatic restart(input cfm_cfg_s c);
    reset = 1'b1;
    cfg = c;
    cyc(2);
    reset = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    reset = 1'b0;
    chk({flag, irq, use_int, freq}, 7'h17);
    chk({1'b0, ctrl_rd}, 7'h1C);
    wr_ctrl(4'hB, CSS_EXT);
    cyc(300);
    chk({ctrl_rd, flag, use_int}, {4'hB, CSS_EXT, 1'b0, 1'b0});
    run = 1'b0;
    wait_flag();
    cyc(1);
    chk({use_int, irq, freq}, 7'h3B);
    ien = 1'b0;
    cyc(2);
    chk(irq, 1'b0);
    cyc(100);
    chk({flag, use_int}, 2'b11);
    run = 1'b1;
    flag_we = 1'b1;
    cyc(1);
    flag_we = 1'b0;
    wr_ctrl(4'hB, CSS_INTERNAL);
    wr_ctrl(4'hB, CSS_EXT);
    cyc(100);
    chk({flag, use_int, stat.fail_active}, 3'b000);
    run = 1'b0;
    wait_flag();
    sleep_exec = 1'b1;
    cyc(1);
    sleep_exec = 1'b0;
    cyc(3);
    chk({stat.fail_active, flag}, 2'b01);
    restart('{1'b0, CFM_EXTERNAL_CLOCK});
    wr_ctrl(4'h7, CSS_EXT);
    cyc(400);
    chk({flag, use_int}, 2'b00);
    restart('{1'b1, CFM_CRYSTAL});
    wr_ctrl(4'h7, CSS_EXT);
    cyc(400);
    chk({flag, use_int}, 2'b01);
    run = 1'b1;
    cyc(4300);
    chk(use_int, 1'b0);
    chk({stat.startup_done, stat.running_external}, 2'b11);
    run = 1'b0;
    wait_flag();
    wake_up = 1'b1;
    flag_we = 1'b1;
    cyc(1);
    wake_up = 1'b0;
    flag_we = 1'b0;
    cyc(300);
    chk({flag, use_int, stat.startup_done}, 3'b010);
    restart('{1'b1, CFM_INTERNAL_ONLY});
    cyc(300);
    chk({flag, use_int}, 2'b01);
    restart('{1'b1, CFM_RESISTOR_CAPACITOR});
    wait_flag();
    report_and_stop();
  end
endmodule // test_clock_fail_monitor
